// >>> verilog/bus_cycle_pkg.sv
// Shared constants and types for the bus cycle sequencer and panel run control
package bus_cycle_pkg;
    // Opcodes: octal 072 and octal 323
    localparam logic [7:0]  OPC_LOAD_ACC     = 8'h3A;
    localparam logic [7:0]  OPC_OUTPUT       = 8'hD3;
    // Status byte bit positions
    localparam int          ST_WO_N          = 1;
    localparam int          ST_OUT           = 4;
    localparam int          ST_FETCH         = 5;
    localparam int          ST_MEMR          = 7;
    // Status bytes per cycle type
    localparam logic [7:0]  STS_FETCH        = 8'hA2;
    localparam logic [7:0]  STS_MEMRD        = 8'h82;
    localparam logic [7:0]  STS_OUTWR        = 8'h10;
    // Reset values and program counter step
    localparam logic [15:0] ADDR_RESET       = 16'h0000;
    localparam logic [15:0] PC_STEP          = 16'h0001;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    // Slow counter and its taps
    localparam int          SLOW_COUNT_W     = 24;
    localparam logic [23:0] SLOW_COUNT_ONE   = 24'h000001;
    localparam logic [23:0] SLOW_COUNT_RESET = 24'h000000;
    localparam int          STOP_TAP_DEFAULT = 13;
    localparam int          SLOW_TAP_DEFAULT = 18;
    // Panel switch vector layout
    localparam int          SWITCH_COUNT     = 4;
    localparam int          SW_STOP          = 0;
    localparam int          SW_RUN           = 1;
    localparam int          SW_STEP          = 2;
    localparam int          SW_SLOW          = 3;

    typedef enum logic [1:0] {T1, T2, T3, TWAIT} tState_t;
    typedef enum logic [1:0] {MC1, MC2, MC3, MC4} mCycle_t;
endpackage : bus_cycle_pkg

// >>> verilog/run_ctrl_if.sv
// Link between the bus cycle sequencer and the panel run control
`timescale 1ns/1ps
`default_nettype none
interface run_ctrl_if;
    logic coincidence;
    logic ready;

    modport cpu (output coincidence, input ready);
    modport ctrl (input coincidence, output ready);
endinterface : run_ctrl_if
`default_nettype wire

// >>> verilog/switch_sync.sv
// Three-stage synchroniser with agreement filter for panel switches
`timescale 1ns/1ps
`default_nettype none
module switch_sync
    import bus_cycle_pkg::*;
#(
    parameter int W = SWITCH_COUNT
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         clkEn,
    // Switches
    input  wire logic [W-1:0] rawIn,
    output wire logic [W-1:0] cleanOut
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic clean_q;
        // First stage feeds only the second
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                s1_q    <= 1'b0;
                s2_q    <= 1'b0;
                s3_q    <= 1'b0;
                clean_q <= 1'b0;
            end else if (clkEn) begin
                s1_q <= rawIn[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    clean_q <= s3_q;
                end
            end
        end
        assign cleanOut[i] = clean_q;
    end
endmodule : switch_sync
`default_nettype wire

// >>> verilog/run_control.sv
// Panel stop, single-step and slow-step control driving the ready line
`timescale 1ns/1ps
`default_nettype none
module run_control
    import bus_cycle_pkg::*;
#(
    parameter int StopTap = STOP_TAP_DEFAULT,
    parameter int SlowTap = SLOW_TAP_DEFAULT
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // Cleaned switches
    input  wire logic stopSw,
    input  wire logic runSw,
    input  wire logic stepSw,
    input  wire logic slowSw,
    // Sequencer link
    run_ctrl_if.ctrl  rc,
    output wire logic panel_ready
);
    logic [SLOW_COUNT_W-1:0] slowCount_q;
    logic                    stopTapPrev_q;
    logic                    slowTapPrev_q;
    logic                    stepSwPrev_q;
    logic                    stopLatch1_q;
    logic                    stopLatch2_q;
    logic                    stop_flip_flop;
    logic                    stepFf_q;
    logic                    stopTick;
    logic                    slowTick;
    logic                    stepSet;

    // Divider giving the stop-sampling and slow-step taps
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slowCount_q   <= SLOW_COUNT_RESET;
            stopTapPrev_q <= 1'b0;
            slowTapPrev_q <= 1'b0;
            stepSwPrev_q  <= 1'b0;
        end else if (clkEn) begin
            slowCount_q   <= slowCount_q + SLOW_COUNT_ONE;
            stopTapPrev_q <= slowCount_q[StopTap];
            slowTapPrev_q <= slowCount_q[SlowTap];
            stepSwPrev_q  <= stepSw;
        end
    end

    assign stopTick = slowCount_q[StopTap] & ~stopTapPrev_q;
    assign slowTick = slowCount_q[SlowTap] & ~slowTapPrev_q;
    assign stepSet  = (stepSw & ~stepSwPrev_q) | (slowSw & slowTick); // RL15 RL18

    // Two latch stages on the stop tap keep a bouncing switch away from the stop flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stopLatch1_q <= 1'b0; // RL19
            stopLatch2_q <= 1'b0; // RL19
        end else if (clkEn && stopTick) begin
            stopLatch1_q <= stopSw; // RL17
            stopLatch2_q <= stopLatch1_q; // RL17
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stop_flip_flop <= 1'b0;
        end else if (clkEn) begin
            if (stopLatch2_q) begin
                stop_flip_flop <= 1'b1; // RL14 RL17
            end else if (runSw) begin
                stop_flip_flop <= 1'b0;
            end
        end
    end

    // Set wins over the fetch coincidence clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stepFf_q <= 1'b0; // RL19
        end else if (clkEn) begin
            if (stepSet) begin
                stepFf_q <= 1'b1; // RL15
            end else if (rc.coincidence) begin
                stepFf_q <= 1'b0; // RL16
            end
        end
    end

    assign panel_ready = ~stop_flip_flop | stepFf_q; // RL13
    assign rc.ready    = panel_ready;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_step_clear: assert property (clkEn && rc.coincidence && !stepSet |=> !stepFf_q) // RL16
        else $error("step control not cleared by fetch coincidence");
    chk_stop_chain: assert property ($rose(stop_flip_flop) |-> $past(stopLatch2_q)) // RL17
        else $error("stop flop set without second latch stage");
    chk_step_ready: assert property (clkEn && stepSet |=> stepFf_q && panel_ready) // RL15
        else $error("step request did not raise ready");
endmodule : run_control
`default_nettype wire

// >>> verilog/bus_output_cycle_and_run_control.sv
// Processor-side bus cycle sequencer for output writes and loads, with panel run control
// Function
// RL1 - Load accumulator: fetch, two address reads, then memory read into accumulator.
// RL2 - Output opcode: fetch, read port number, then output write cycle.
// RL3 - Output: program counter held after port read, bumped after write.
// RL4 - Output write cycle spans three clock periods, one step each.
// RL5 - Late first period: port on address, status on data, sync high.
// RL6 - Second period start: status strobe pulse latches output and write qualifiers.
// RL7 - Output qualifier blocks the memory write strobe.
// RL8 - I/O card selects itself from qualifier, sync and port address.
// RL9 - Third period start: byte driven on data-out lines.
// RL10 - Write strobe goes low once data-out is stable.
// RL11 - Selected I/O card captures data on the write strobe.
// RL12 - Qualifiers and address drive output, write-out and address lamps.
// RL13 - Ready line low means wait, high means run.
// RL14 - Stop deasserts run; wait entered only at fetch coincidence.
// RL15 - Single step or slow sets step control for one instruction.
// RL16 - Next fetch coincidence clears step control and forces wait.
// RL17 - Stop switch passes two slow-tap latch stages before the stop flop; here both latches are clocked from the stop tap (StopTap), not SlowTap.
// RL18 - Slow mode retriggers steps from a 24-bit counter tap.
// RL19 - Reset clears stop latches, step control, write strobe and qualifiers.
`timescale 1ns/1ps
`default_nettype none
module bus_output_cycle_and_run_control
    import bus_cycle_pkg::*;
#(
    parameter int StopTap = STOP_TAP_DEFAULT,
    parameter int SlowTap = SLOW_TAP_DEFAULT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // Panel switches
    input  wire logic        stopSwitch,
    input  wire logic        runSwitch,
    input  wire logic        stepSwitch,
    input  wire logic        slowSwitch,
    // Backplane bus
    output var  logic [15:0] address_lines,
    output var  logic [7:0]  statusLines,
    output var  logic        bus_cycle_sync,
    output var  logic        status_strobe_n,
    output var  logic        output_cycle_qual,
    output var  logic        write_out_qual_n,
    output wire logic        fetch_status_bit,
    output var  logic [7:0]  data_out_lines,
    output var  logic        bus_write_strobe_n,
    output wire logic        memory_write_strobe,
    output var  logic        data_in_enable_n,
    input  wire logic [7:0]  dataInLines,
    // Panel
    output wire logic        panel_ready,
    output wire logic        lampOut,
    output wire logic        lampWriteOut,
    output wire logic [15:0] lampAddress,
    output var  logic [7:0]  accumulator,
    output var  logic [15:0] programCounter
);
    tState_t     tState_q;
    mCycle_t     mCycle_q;
    mCycle_t     nextCycle;
    logic        phase_q;
    logic [7:0]  opcode_q;
    logic [7:0]  port_q;
    logic [7:0]  addrLo_q;
    logic [7:0]  addrHi_q;
    logic [15:0] cycleAddr;
    logic [7:0]  cycleStatus;
    logic        writeCycle;
    logic        endT1a;
    logic        endT1b;
    logic        endT2a;
    logic        enterT3;
    logic        endT3a;
    logic        endT3b;
    logic [3:0]  swClean;

    run_ctrl_if rc ();

    switch_sync #(
        .W (SWITCH_COUNT)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .rawIn    ({slowSwitch, stepSwitch, runSwitch, stopSwitch}),
        .cleanOut (swClean)
    );

    run_control #(
        .StopTap (StopTap),
        .SlowTap (SlowTap)
    ) u_run (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .clkEn       (clkEn),
        .stopSw      (swClean[SW_STOP]),
        .runSw       (swClean[SW_RUN]),
        .stepSw      (swClean[SW_STEP]),
        .slowSw      (swClean[SW_SLOW]),
        .rc          (rc.ctrl),
        .panel_ready (panel_ready)
    );

    // Fetch coincidence: sync, status strobe and fetch bit together
    assign rc.coincidence = bus_cycle_sync & ~status_strobe_n & statusLines[ST_FETCH]; // RL14 RL16
    assign fetch_status_bit = statusLines[ST_FETCH];

    // Step points: T1, T2 and T3 are each split into two phases of the system clock
    assign endT1a  = (tState_q == T1) && !phase_q;
    assign endT1b  = (tState_q == T1) && phase_q;
    assign endT2a  = (tState_q == T2) && !phase_q;
    assign enterT3 = ((tState_q == T2) && phase_q && !(mCycle_q == MC1 && !rc.ready))
                   || ((tState_q == TWAIT) && rc.ready);
    assign endT3a  = (tState_q == T3) && !phase_q;
    assign endT3b  = (tState_q == T3) && phase_q;

    assign writeCycle = (opcode_q == OPC_OUTPUT) && (mCycle_q == MC3); // RL2

    always_comb begin
        nextCycle = MC1;
        case (mCycle_q)
            MC1: begin
                if (opcode_q == OPC_LOAD_ACC || opcode_q == OPC_OUTPUT) begin
                    nextCycle = MC2; // RL1 RL2
                end
            end
            MC2: nextCycle = MC3;
            MC3: begin
                if (opcode_q == OPC_LOAD_ACC) begin
                    nextCycle = MC4; // RL1
                end
            end
            MC4: nextCycle = MC1;
            default: nextCycle = MC1;
        endcase
    end

    always_comb begin
        cycleAddr   = programCounter;
        cycleStatus = STS_MEMRD;
        if (mCycle_q == MC1) begin
            cycleStatus = STS_FETCH;
        end else if (writeCycle) begin
            cycleAddr   = {port_q, port_q}; // RL5
            cycleStatus = STS_OUTWR;
        end else if (mCycle_q == MC4) begin
            cycleAddr = {addrHi_q, addrLo_q}; // RL1
        end
    end

    // Period sequencer; the wait state is only reachable from the fetch cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tState_q <= T1;
            mCycle_q <= MC1;
            phase_q  <= 1'b0;
        end else if (clkEn) begin
            case (tState_q)
                T1: begin
                    phase_q <= ~phase_q;
                    if (phase_q) begin
                        tState_q <= T2; // RL4
                    end
                end
                T2: begin
                    phase_q <= ~phase_q;
                    if (phase_q) begin
                        tState_q <= enterT3 ? T3 : TWAIT; // RL13 RL14
                    end
                end
                TWAIT: begin
                    if (enterT3) begin
                        tState_q <= T3; // RL13
                    end
                end
                T3: begin
                    phase_q <= ~phase_q;
                    if (phase_q) begin
                        tState_q <= T1; // RL4
                        mCycle_q <= nextCycle;
                    end
                end
                default: begin
                    tState_q <= T1;
                    phase_q  <= 1'b0;
                end
            endcase
        end
    end

    // Address, status and sync presented late in the first period
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            address_lines    <= ADDR_RESET;
            statusLines      <= BYTE_RESET;
            bus_cycle_sync   <= 1'b0;
            data_in_enable_n <= 1'b1;
        end else if (clkEn) begin
            if (endT1a) begin
                address_lines    <= cycleAddr; // RL5
                statusLines      <= cycleStatus; // RL5
                bus_cycle_sync   <= 1'b1; // RL5
                data_in_enable_n <= 1'b0;
            end else if (endT2a) begin
                bus_cycle_sync   <= 1'b0;
                data_in_enable_n <= writeCycle ? 1'b0 : 1'b1;
            end else if (endT3b) begin
                data_in_enable_n <= 1'b1;
            end
        end
    end

    // Status strobe pulse and the qualifier latch it loads on its rising edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_strobe_n   <= 1'b1;
            output_cycle_qual <= 1'b0; // RL19
            write_out_qual_n  <= 1'b1; // RL19
        end else if (clkEn) begin
            if (endT1b) begin
                status_strobe_n <= 1'b0; // RL6
            end else if (endT2a) begin
                status_strobe_n   <= 1'b1; // RL6
                output_cycle_qual <= statusLines[ST_OUT]; // RL6
                write_out_qual_n  <= statusLines[ST_WO_N]; // RL6
            end
        end
    end

    // Data out at the start of the third period, strobe one phase later
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out_lines     <= BYTE_RESET;
            bus_write_strobe_n <= 1'b1; // RL19
        end else if (clkEn) begin
            if (enterT3 && writeCycle) begin
                data_out_lines <= accumulator; // RL9
            end
            if (endT3a && writeCycle) begin
                bus_write_strobe_n <= 1'b0; // RL10
            end else if (endT3b) begin
                bus_write_strobe_n <= 1'b1; // RL4
            end
        end
    end

    // Output qualifier gates the memory strobe so port writes never reach memory
    assign memory_write_strobe = ~bus_write_strobe_n & ~output_cycle_qual; // RL7

    // Read data captured mid third period
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            opcode_q    <= BYTE_RESET;
            port_q      <= BYTE_RESET;
            addrLo_q    <= BYTE_RESET;
            addrHi_q    <= BYTE_RESET;
            accumulator <= BYTE_RESET;
        end else if (clkEn && endT3a && !writeCycle) begin
            case (mCycle_q)
                MC1: opcode_q <= dataInLines; // RL1 RL2
                MC2: begin
                    if (opcode_q == OPC_OUTPUT) begin
                        port_q <= dataInLines; // RL2
                    end else begin
                        addrLo_q <= dataInLines; // RL1
                    end
                end
                MC3: addrHi_q <= dataInLines; // RL1
                MC4: accumulator <= dataInLines; // RL1
                default: opcode_q <= opcode_q;
            endcase
        end
    end

    // Program counter: held across the port read until the write completes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            programCounter <= ADDR_RESET;
        end else if (clkEn && endT3b) begin
            if (!(mCycle_q == MC2 && opcode_q == OPC_OUTPUT) && mCycle_q != MC4) begin
                programCounter <= programCounter + PC_STEP; // RL3
            end
        end
    end

    // Panel lamps follow the bus qualifiers and address
    assign lampOut      = output_cycle_qual; // RL12
    assign lampWriteOut = ~write_out_qual_n; // RL12
    assign lampAddress  = address_lines; // RL12

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seqSyncHeld;
        bus_cycle_sync && $past(bus_cycle_sync);
    endsequence

    sequence seqWriteQualified;
        output_cycle_qual && !write_out_qual_n && address_lines == {port_q, port_q};
    endsequence

    sequence seqWriteToT3a;
        endT1a && writeCycle && clkEn ##1 clkEn[*4];
    endsequence

    chk_strobe_after_sync: assert property ($fell(status_strobe_n) |-> seqSyncHeld) // RL5
        else $error("status strobe without sync held from first period");
    chk_strobe_one_phase: assert property (!status_strobe_n && clkEn |=> status_strobe_n) // RL6
        else $error("status strobe longer than one phase");
    chk_write_qualified: assert property ($fell(bus_write_strobe_n) |-> seqWriteQualified) // RL6
        else $error("write strobe without output qualifiers and port address");
    chk_mem_write_block: assert property (output_cycle_qual |-> !memory_write_strobe) // RL7
        else $error("memory write strobe during output cycle");
    chk_dout_stable: assert property ($fell(bus_write_strobe_n) |-> $stable(data_out_lines)) // RL10
        else $error("data out changed with write strobe");
    chk_dout_value: assert property (!bus_write_strobe_n |-> data_out_lines == accumulator) // RL9
        else $error("data out not the accumulator");
    chk_pc_hold_out: assert property (clkEn && endT3b && mCycle_q == MC2 && opcode_q == OPC_OUTPUT // RL3
                                      |=> $stable(programCounter))
        else $error("program counter moved after port read");
    chk_load_acc: assert property (clkEn && endT3a && mCycle_q == MC4 |=> accumulator == $past(dataInLines)) // RL1
        else $error("accumulator not loaded in fourth cycle");
    chk_wait_at_fetch: assert property (tState_q == TWAIT |-> mCycle_q == MC1 && statusLines[ST_FETCH]) // RL14
        else $error("wait outside fetch cycle");
    chk_wait_not_ready: assert property ($rose(tState_q == TWAIT) |-> !$past(panel_ready)) // RL13
        else $error("wait entered while ready");
    // Strobe is registered at the end of T3a, so it is seen one edge after the run of enables
    chk_write_periods: assert property (seqWriteToT3a |=> !bus_write_strobe_n && output_cycle_qual) // RL4
        else $error("write strobe not in third period");
endmodule : bus_output_cycle_and_run_control
`default_nettype wire

// >>> verif/io_mem_card.sv
// Memory and output-port card model on the backplane bus
`timescale 1ns/1ps
`default_nettype none
module io_mem_card (
    // Clock
    input  wire logic        clk,
    // Bus from the processor board
    input  wire logic [15:0] address_lines,
    input  wire logic        bus_cycle_sync,
    input  wire logic        output_cycle_qual,
    input  wire logic        data_in_enable_n,
    input  wire logic [7:0]  data_out_lines,
    input  wire logic        bus_write_strobe_n,
    output var  logic [7:0]  dataInLines,
    // Captured output write
    output var  logic        wrSeen,
    output var  logic [15:0] wrAddr,
    output var  logic [7:0]  wrData
);
    logic [7:0]  mem [0:255];
    logic [7:0]  lastByte = 8'h00;
    logic [15:0] syncAddr = 16'h0000;
    logic        strobeQ = 1'b1;
    // Released lines toggle so a stale byte can never pass for read data
    always_comb begin
        if (data_in_enable_n && !output_cycle_qual) begin
            dataInLines = mem[address_lines[7:0]];
        end else begin
            dataInLines = ~lastByte;
        end
    end
    always_ff @(posedge clk) begin
        lastByte <= dataInLines;
        strobeQ  <= bus_write_strobe_n;
        if (bus_cycle_sync) begin
            syncAddr <= address_lines;
        end
        // Falling strobe only, since a frozen clock enable may stretch it
        wrSeen <= strobeQ & ~bus_write_strobe_n & output_cycle_qual;
        wrAddr <= syncAddr;
        wrData <= data_out_lines;
    end
endmodule : io_mem_card
`default_nettype wire

// >>> verif/bus_output_cycle_and_run_control_tb_top.sv
// Self-checking bench for the bus output cycle and panel run control
`timescale 1ns/1ps
`default_nettype none
module bus_output_cycle_and_run_control_tb_top import bus_cycle_pkg::*;;
    logic        clk, sys_rst, clkEn, stopSw, runSw, stepSw, slowSw;
    logic [15:0] addr, lampAddr, pc, wrAddr, pcAtWr;
    logic [7:0]  sts, dataIn, dataOut, acc, wrData;
    logic        wrN, memWr, outQ, woN, ready, lOut, lWo, dienN, wrSeen, lampsOk;
    logic        sync, stbN, fetchBit;
    logic [40:0] notes[$];
    logic [40:0] expd;
    logic [31:0] rnd = 32'h851D;
    int          errors = 0;
    int          n_compared = 0;

    bus_output_cycle_and_run_control #(.StopTap(3), .SlowTap(5)) bus_output_cycle_and_run_control_inst (
        .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .stopSwitch(stopSw), .runSwitch(runSw),
        .stepSwitch(stepSw), .slowSwitch(slowSw), .address_lines(addr), .statusLines(sts),
        .bus_cycle_sync(sync), .status_strobe_n(stbN), .output_cycle_qual(outQ), .write_out_qual_n(woN),
        .fetch_status_bit(fetchBit), .data_out_lines(dataOut), .bus_write_strobe_n(wrN),
        .memory_write_strobe(memWr), .data_in_enable_n(dienN), .dataInLines(dataIn),
        .panel_ready(ready), .lampOut(lOut), .lampWriteOut(lWo), .lampAddress(lampAddr),
        .accumulator(acc), .programCounter(pc));
    io_mem_card io_mem_card_inst (
        .clk(clk), .address_lines(addr), .bus_cycle_sync(sync),
        .output_cycle_qual(outQ), .data_in_enable_n(dienN), .data_out_lines(dataOut),
        .bus_write_strobe_n(wrN), .dataInLines(dataIn), .wrSeen(wrSeen), .wrAddr(wrAddr), .wrData(wrData));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc

    task automatic check(input logic [40:0] got, input logic [40:0] want);
        n_compared++;
        if (got !== want) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : check

    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Random clock enable drops about one clock in four to stretch cycles in earnest
    always @(posedge clk) begin
        #2;
        rnd = xs(rnd);
        clkEn = (rnd[1:0] != 2'h0);
    end

    // Write strobe is sampled mid-cycle, before the counter moves on
    always @(negedge clk) begin
        if (wrN === 1'b0 && outQ === 1'b1) begin
            pcAtWr = pc;
            lampsOk = lOut & lWo & (lampAddr === addr) & (memWr === 1'b0) & (woN === 1'b0);
            // Sync and status strobe are both over by the third period
            lampsOk = lampsOk & (sync === 1'b0) & (stbN === 1'b1);
        end
        if (wrSeen === 1'b1) begin
            expd = (notes.size() > 0) ? notes.pop_front() : '1;
            check({lampsOk, pcAtWr, wrAddr, wrData}, expd);
        end
    end

    initial begin
        logic [7:0]  v, p1, p2, tgt;
        logic [15:0] pc0;
        int          i;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        stopSw = 1'b0;
        runSw = 1'b0;
        stepSw = 1'b0;
        slowSw = 1'b0;
        v = rnd[7:0];
        p1 = rnd[15:8];
        p2 = rnd[23:16];
        tgt = 8'hC0 | {3'h0, rnd[28:24]};
        for (i = 0; i < 256; i++) io_mem_card_inst.mem[i] = 8'h00;
        io_mem_card_inst.mem[0] = OPC_LOAD_ACC;
        io_mem_card_inst.mem[1] = tgt;
        io_mem_card_inst.mem[3] = OPC_OUTPUT;
        io_mem_card_inst.mem[4] = p1;
        io_mem_card_inst.mem[5] = OPC_OUTPUT;
        io_mem_card_inst.mem[6] = p2;
        io_mem_card_inst.mem[tgt] = v;
        notes.push_back({1'b1, 16'h0004, p1, p1, v});
        notes.push_back({1'b1, 16'h0006, p2, p2, v});
        cyc(12);
        check(41'({wrN, outQ, woN}), 41'h5);
        sys_rst = 1'b0;
        for (i = 0; i < 600 && notes.size() > 0; i++) cyc(1);
        check(41'(notes.size()), 41'h0);
        if (notes.size() > 0) finish_test();
        // Stop must pass the stop-tap latches before the ready line drops
        stopSw = 1'b1;
        for (i = 0; i < 400 && ready !== 1'b0; i++) cyc(1);
        check(41'(ready), 41'h0);
        if (ready !== 1'b0) finish_test();
        stopSw = 1'b0;
        cyc(100);
        pc0 = pc;
        cyc(60);
        check(41'({pc, sts, fetchBit}), 41'({pc0, STS_FETCH, 1'b1}));
        stepSw = 1'b1;
        cyc(20);
        stepSw = 1'b0;
        cyc(150);
        check(41'({pc, ready}), 41'({pc0 + 16'h0001, 1'b0}));
        pc0 = pc;
        slowSw = 1'b1;
        cyc(300);
        slowSw = 1'b0;
        cyc(100);
        check(41'((pc - pc0 >= 16'h2) && (pc - pc0 <= 16'h6)), 41'h1);
        runSw = 1'b1;
        cyc(20);
        runSw = 1'b0;
        for (i = 0; i < 100 && ready !== 1'b1; i++) cyc(1);
        check(41'(ready), 41'h1);
        pc0 = pc;
        cyc(200);
        check(41'(pc - pc0 > 16'hA), 41'h1);
        finish_test();
    end
endmodule : bus_output_cycle_and_run_control_tb_top
`default_nettype wire
